// ### rtl/cgs_status.sv
// cgs_status: status, sticky flags and interrupt logic of the
// clock generator, with its software register port
// assumes: detector inputs are on clk_i; only the raw oscillator clock
// pin comes from outside and is synchronised here
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - bits 7:6 report active clock mode
// - mode status lags requested mode by handover
// - bit 5 shows chosen reference, 1 oscillator
// - bit 4 sticky lock loss until cleared
// - bit 3 lock, zero outside engaged modes
// - bit 2 sticky clock loss until cleared
// - bit 1 external reference stable and fast
// - bit 0 interrupt flag shows pending request
// - clear by read then write one; reset
// - new interrupt restarts the clear sequence
// - writing zero leaves interrupt flag alone
// - oscillator stable needs quiet samples, live clock
// - leaving off, engaged mode waits oscillator stable
// - self-clocked monitoring starts after oscillator stable
// - oscillator stable cleared on entering off
// - lock loss action: interrupt or reset request
// - clock loss action: interrupt or reset request
module cgs_status
  import cgs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              gen_off_i,
  input  wire logic              lock_i,
  input  wire logic              clk_loss_i,
  input  wire logic              ext_ref_ok_i,
  input  wire logic              ref_osc_sel_i,
  input  wire logic [ERR_W-1:0]  count_err_i,
  input  wire logic              count_valid_i,
  input  wire logic              osc_output_clock_i,
  output logic      [1:0]        clock_mode_status_o,
  output logic                   osc_monitor_en_o,
  output logic                   reset_req_o,
  output logic                   irq_o
);

  cgs_osc_if osc_if ();

  // register port decode
  logic              wr_st1;
  logic              rd_st1;
  logic              wr_ctl;
  logic              wr_evt;
  logic              wr_msk;
  // software state
  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] evt_ff;
  logic [DATA_W-1:0] mask_ff;
  logic [DATA_W-1:0] rdata_ff;
  // oscillator pin synchroniser
  logic              dco_s1_ff;
  logic              dco_s2_ff;
  // mode tracking
  cgs_mode_t         hand_ff [2];
  cgs_mode_t         mode_ff;
  cgs_mode_t         nxt_mode;
  logic              off_prev_ff;
  logic              wait_osc_ff;
  logic              leaving_off;
  logic              wait_c;
  logic              engaged;
  // flags
  logic              lock_ff;
  logic              lock_c;
  logic              lol_ff;
  logic              lol_set;
  logic              loc_ff;
  logic              irq_ff;
  logic              irq_set;
  logic              arm_ff;
  logic              osc_prev_ff;
  logic              osc_stable;
  logic              lol_act;
  logic              loc_act;
  logic              mon_ff;
  logic [DATA_W-1:0] ev_set;
  logic [DATA_W-1:0] stat1;
  logic [DATA_W-1:0] stat2;

  // register port strobes
  assign wr_st1 = wr_i && (addr_i == OFS_STAT1);
  assign rd_st1 = rd_i && (addr_i == OFS_STAT1);
  assign wr_ctl = wr_i && (addr_i == OFS_CTRL);
  assign wr_evt = wr_i && (addr_i == OFS_EVT);
  assign wr_msk = wr_i && (addr_i == OFS_MASK);

  assign lol_act = ctrl_ff[CTL_LOL_ACT];
  assign loc_act = ctrl_ff[CTL_LOC_ACT];

  // raw oscillator clock is asynchronous; only edges matter downstream
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dco_s1_ff <= 1'b0;
      dco_s2_ff <= 1'b0;
    end
    else
    begin
      dco_s1_ff <= osc_output_clock_i;
      dco_s2_ff <= dco_s1_ff;
    end
  end

  // stability checker hookup
  assign osc_if.gen_off   = gen_off_i;
  assign osc_if.err       = count_err_i;
  assign osc_if.err_valid = count_valid_i;
  assign osc_if.dco_lvl   = dco_s2_ff;
  assign osc_stable       = osc_if.stable;

  cgs_osc_stab u_osc_stab (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .osc   (osc_if.det)
  );

  // control register: action selects and requested mode
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_ff <= CTRL_RST;
    else if (wr_ctl)
      ctrl_ff <= wdata_i;
  end

  // requested mode walks two stages before the mode logic sees it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hand_ff[0] <= CGS_SELF;
      hand_ff[1] <= CGS_SELF;
    end
    else
    begin
      hand_ff[0] <= cgs_mode_t'(ctrl_ff[CTL_MODE_LO +: 2]);
      hand_ff[1] <= hand_ff[0];
    end
  end

  // leaving off with an engaged mode parks in self-clocked first
  assign leaving_off = off_prev_ff && !gen_off_i;
  assign wait_c      = wait_osc_ff || (leaving_off && hand_ff[1][0]);

  always_comb
  begin
    nxt_mode = mode_ff;
    if (gen_off_i)
      nxt_mode = mode_ff;
    else if (wait_c && !osc_stable)
      nxt_mode = CGS_SELF;
    else if ((hand_ff[1] == CGS_FBE) && !ext_ref_ok_i)
      nxt_mode = mode_ff;
    else
      nxt_mode = hand_ff[1];
  end

  // active mode and the off-exit wait
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_ff     <= CGS_SELF;
      off_prev_ff <= 1'b0;
      wait_osc_ff <= 1'b0;
    end
    else
    begin
      mode_ff     <= nxt_mode;
      off_prev_ff <= gen_off_i;
      wait_osc_ff <= wait_c && !osc_stable && !gen_off_i;
    end
  end

  // lock shows only in engaged modes
  assign engaged = (mode_ff == CGS_FEI) || (mode_ff == CGS_FEE);
  assign lock_c  = lock_i && engaged && !gen_off_i;
  // a drop without a mode change or off entry is unexpected
  assign lol_set = lock_ff && !lock_c && engaged && !gen_off_i &&
                   (nxt_mode == mode_ff);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      lock_ff <= 1'b0;
    else
      lock_ff <= lock_c;
  end

  // sticky loss flags; a new event beats a same-cycle clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lol_ff <= 1'b0;
      loc_ff <= 1'b0;
    end
    else
    begin
      lol_ff <= lol_set ||
                (lol_ff && !(wr_st1 && wdata_i[ST1_LOL]));
      loc_ff <= clk_loss_i ||
                (loc_ff && !(wr_st1 && wdata_i[ST1_LOC]));
    end
  end

  // interrupt action chosen per source at the moment of the event
  assign irq_set = (lol_set && !lol_act) ||
                   (clk_loss_i && !loc_act);

  // interrupt flag with read-then-write-one clear; arm_ff remembers
  // the read, and a fresh request disarms so the flag survives
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_ff <= 1'b0;
      arm_ff <= 1'b0;
    end
    else if (irq_set)
    begin
      irq_ff <= 1'b1;
      arm_ff <= 1'b0;
    end
    else if (wr_st1)
    begin
      if (wdata_i[ST1_IRQ] && arm_ff)
        irq_ff <= 1'b0;
      arm_ff <= 1'b0;
    end
    else if (rd_st1 && irq_ff)
      arm_ff <= 1'b1;
  end

  // reset request stays while a flag with reset action is set
  assign reset_req_o = (lol_ff && lol_act) ||
                       (loc_ff && loc_act);

  // monitoring in self-clocked mode waits for a stable oscillator
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      mon_ff <= 1'b0;
    else
      mon_ff <= !gen_off_i &&
                ((mode_ff != CGS_SELF) || osc_stable);
  end

  // event sources for the system interrupt
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      osc_prev_ff <= 1'b0;
    else
      osc_prev_ff <= osc_stable;
  end

  always_comb
  begin
    ev_set          = 8'h00;
    ev_set[EV_IRQ]  = irq_set;
    ev_set[EV_LOL]  = lol_set;
    ev_set[EV_LOC]  = clk_loss_i;
    ev_set[EV_OSC]  = osc_stable && !osc_prev_ff;
    ev_set[EV_MODE] = nxt_mode != mode_ff;
  end

  // event status is write-one-to-clear, set wins; mask is plain
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      evt_ff  <= EVT_RST;
      mask_ff <= MASK_RST;
    end
    else
    begin
      evt_ff <= ev_set | (evt_ff & ~(wr_evt ? wdata_i : 8'h00));
      if (wr_msk)
        mask_ff <= wdata_i;
    end
  end

  assign irq_o = |(evt_ff & mask_ff);

  // status images
  always_comb
  begin
    stat1                    = 8'h00;
    stat1[ST1_MODE_LO +: 2]  = mode_ff;
    stat1[ST1_REF]           = ref_osc_sel_i;
    stat1[ST1_LOL]           = lol_ff;
    stat1[ST1_LOCK]          = lock_ff;
    stat1[ST1_LOC]           = loc_ff;
    stat1[ST1_ERS]           = ext_ref_ok_i;
    stat1[ST1_IRQ]           = irq_ff;
    stat2                    = 8'h00;
    stat2[ST2_OSC]           = osc_stable;
  end

  // read data stand one cycle only; unmapped indices read zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_ff <= 8'h00;
    else if (rd_i)
    begin
      unique case (addr_i)
        OFS_STAT1: rdata_ff <= stat1;
        OFS_STAT2: rdata_ff <= stat2;
        OFS_CTRL:  rdata_ff <= ctrl_ff;
        OFS_EVT:   rdata_ff <= evt_ff;
        OFS_MASK:  rdata_ff <= mask_ff;
        default:   rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end

  assign rdata_o             = rdata_ff;
  assign clock_mode_status_o = mode_ff;
  assign osc_monitor_en_o    = mon_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  mode_lag_a : assert property (
    $changed(mode_ff) |-> (mode_ff == $past(hand_ff[1])) ||
                          (mode_ff == CGS_SELF))
    else $error("mode status moved to a value not handed over");

  mode_hold_a : assert property (
    gen_off_i |=> $stable(mode_ff))
    else $error("mode status changed while generator is off");

  lock_force_a : assert property (
    (!engaged || gen_off_i) |=> !lock_ff)
    else $error("lock shown outside an engaged mode");

  lol_sticky_a : assert property (
    lol_ff && !(wr_st1 && wdata_i[ST1_LOL]) |=> lol_ff)
    else $error("lock loss flag dropped without a clear");

  loc_set_a : assert property (
    clk_loss_i |=> loc_ff)
    else $error("clock loss flag not set after loss");

  irq_keep_a : assert property (
    irq_ff && wr_st1 && !wdata_i[ST1_IRQ] |=> irq_ff)
    else $error("writing zero cleared the interrupt flag");

  irq_clear_a : assert property (
    (rd_st1 && irq_ff && !irq_set) ##1
    (wr_st1 && wdata_i[ST1_IRQ] && !irq_set) |=> !irq_ff)
    else $error("read then write one did not clear the flag");

  irq_renew_a : assert property (
    irq_set ##1 (wr_st1 && wdata_i[ST1_IRQ] && !irq_set) |=> irq_ff)
    else $error("new interrupt lost to an earlier clear sequence");

  irq_raise_a : assert property (
    clk_loss_i && !loc_act |=> irq_ff && loc_ff)
    else $error("clock loss with interrupt action raised no flag");

  reset_req_a : assert property (
    $rose(loc_ff) && loc_act |-> reset_req_o && !$past(irq_set))
    else $error("clock loss with reset action gave no reset request");

  osc_wait_a : assert property (
    leaving_off && hand_ff[1][0] && !osc_stable |=>
    mode_ff == CGS_SELF ##1 (mode_ff == CGS_SELF || osc_stable))
    else $error("engaged mode taken before oscillator stable");

  ext_ref_a : assert property (
    rd_st1 |=> rdata_o[ST1_ERS] == $past(ext_ref_ok_i) &&
               rdata_o[ST1_REF] == $past(ref_osc_sel_i))
    else $error("reference status bits do not follow their inputs");

  monitor_a : assert property (
    mode_ff == CGS_SELF && !osc_stable |=> !osc_monitor_en_o)
    else $error("monitoring started before oscillator stable");

endmodule : cgs_status

`default_nettype wire

// ### rtl/cgs_pkg.sv
// cgs_pkg: constants and types of the clock generator status block
// assumes: one 50 MHz system clock and a byte-wide register port
package cgs_pkg;

  // register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int ERR_W  = 12;

  // register indices
  localparam logic [2:0] OFS_STAT1 = 3'h0;
  localparam logic [2:0] OFS_STAT2 = 3'h1;
  localparam logic [2:0] OFS_CTRL  = 3'h2;
  localparam logic [2:0] OFS_EVT   = 3'h3;
  localparam logic [2:0] OFS_MASK  = 3'h4;

  // primary status fields
  localparam int ST1_MODE_LO = 6;
  localparam int ST1_REF     = 5;
  localparam int ST1_LOL     = 4;
  localparam int ST1_LOCK    = 3;
  localparam int ST1_LOC     = 2;
  localparam int ST1_ERS     = 1;
  localparam int ST1_IRQ     = 0;
  // secondary status and control fields
  localparam int ST2_OSC     = 0;
  localparam int CTL_LOL_ACT = 7;
  localparam int CTL_LOC_ACT = 3;
  localparam int CTL_MODE_LO = 0;
  // event status and mask layout
  localparam int EV_IRQ  = 0;
  localparam int EV_LOL  = 1;
  localparam int EV_LOC  = 2;
  localparam int EV_OSC  = 3;
  localparam int EV_MODE = 4;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] EVT_RST  = 8'h00;

  // stability detection
  localparam logic [11:0] UNLOCK_THRESH = 12'h004;
  localparam logic [1:0]  GOOD_NEEDED   = 2'h2;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int DCO_STATIC_NS  = 1000;
  localparam int DCO_STATIC_CYC =
    (DCO_STATIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATIC_W = 6;

  // active clock mode, in status field order
  typedef enum logic [1:0] {
    CGS_SELF,
    CGS_FEI,
    CGS_FBE,
    CGS_FEE
  } cgs_mode_t;

endpackage : cgs_pkg

// ### rtl/cgs_osc_if.sv
// cgs_osc_if: link between status logic and oscillator stability check
// assumes: both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none

interface cgs_osc_if;
  import cgs_pkg::*;

  logic             gen_off;
  logic [ERR_W-1:0] err;
  logic             err_valid;
  logic             dco_lvl;
  logic             stable;

  modport ctrl (output gen_off, output err, output err_valid,
                output dco_lvl, input stable);
  modport det  (input gen_off, input err, input err_valid,
                input dco_lvl, output stable);
endinterface : cgs_osc_if

`default_nettype wire

// ### rtl/cgs_osc_stab.sv
// cgs_osc_stab: decides whether the oscillator output clock is stable
// assumes: dco_lvl already synchronised, err sampled on clk_i
`timescale 1ns/10ps
`default_nettype none

module cgs_osc_stab
  import cgs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  cgs_osc_if.det    osc
);
  logic [ERR_W-1:0]    prev_err_ff;
  logic                prev_ok_ff;
  logic [1:0]          good_cnt_ff;
  logic [STATIC_W-1:0] static_cnt_ff;
  logic                dco_prev_ff;
  logic                stable_ff;
  logic [ERR_W-1:0]    err_delta;
  logic                delta_ok;
  logic                toggling;

  // magnitude of the change between two error samples
  always_comb
  begin
    if (osc.err >= prev_err_ff)
      err_delta = osc.err - prev_err_ff;
    else
      err_delta = prev_err_ff - osc.err;
  end

  assign delta_ok = prev_ok_ff && (err_delta <= UNLOCK_THRESH);
  assign toggling = static_cnt_ff < STATIC_W'(DCO_STATIC_CYC);

  // edge watchdog; starts out as static so no edge means no stability
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dco_prev_ff   <= 1'b0;
      static_cnt_ff <= STATIC_W'(DCO_STATIC_CYC);
    end
    else
    begin
      dco_prev_ff <= osc.dco_lvl;
      if (osc.dco_lvl != dco_prev_ff)
        static_cnt_ff <= '0;
      else if (toggling)
        static_cnt_ff <= static_cnt_ff + STATIC_W'(1);
    end
  end

  // run of consecutive quiet samples; the first sample has no partner
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_err_ff <= '0;
      prev_ok_ff  <= 1'b0;
      good_cnt_ff <= 2'h0;
    end
    else if (osc.gen_off)
    begin
      prev_ok_ff  <= 1'b0;
      good_cnt_ff <= 2'h0;
    end
    else if (osc.err_valid)
    begin
      prev_err_ff <= osc.err;
      prev_ok_ff  <= 1'b1;
      if (!delta_ok)
        good_cnt_ff <= 2'h0;
      else if (good_cnt_ff != GOOD_NEEDED)
        good_cnt_ff <= good_cnt_ff + 2'h1;
    end
  end

  // stable only with two quiet samples and a live clock, never when off
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      stable_ff <= 1'b0;
    else
      stable_ff <= !osc.gen_off && toggling &&
                   (good_cnt_ff == GOOD_NEEDED);
  end

  assign osc.stable = stable_ff;

  stable_off_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    osc.gen_off |=> !stable_ff)
    else $error("oscillator stable flag kept in off state");

  stable_cause_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(stable_ff) |-> $past(good_cnt_ff) == GOOD_NEEDED &&
                         $past(toggling))
    else $error("oscillator stable flag rose without two quiet samples");

  stable_static_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    !toggling |=> !stable_ff)
    else $error("oscillator stable flag set while clock is static");

endmodule : cgs_osc_stab

`default_nettype wire

// ### testbench/cgs_status_tb_top.sv
// cgs_status_tb_top: self-checking bench for the clock generator status
// assumes: cgs_pkg compiled first; bench drives every port of cgs_status
`timescale 1ns/10ps
`default_nettype none

// one compare, counted; unknowns never match
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module cgs_status_tb_top
  import cgs_pkg::*;
;
  logic              clk_i         = 1'b0;
  logic              rst_i         = 1'b1;
  logic [ADDR_W-1:0] addr_i        = '0;
  logic [DATA_W-1:0] wdata_i       = '0;
  logic              wr_i          = 1'b0;
  logic              rd_i          = 1'b0;
  logic              gen_off_i     = 1'b0;
  logic              lock_i        = 1'b0;
  logic              clk_loss_i    = 1'b0;
  logic              ext_ref_ok_i  = 1'b0;
  logic              ref_osc_sel_i = 1'b0;
  logic [ERR_W-1:0]  count_err_i   = '0;
  logic              count_valid_i = 1'b0;
  logic              osc_clk       = 1'b0;
  logic              osc_run       = 1'b1;
  logic [DATA_W-1:0] rdata_o;
  logic [1:0]        mode_o;
  logic              mon_o;
  logic              reset_req_o;
  logic              irq_o;
  int                num_errors    = 0;
  int                num_checks    = 0;

  cgs_status dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .addr_i             (addr_i),
    .wdata_i            (wdata_i),
    .wr_i               (wr_i),
    .rd_i               (rd_i),
    .rdata_o            (rdata_o),
    .gen_off_i          (gen_off_i),
    .lock_i             (lock_i),
    .clk_loss_i         (clk_loss_i),
    .ext_ref_ok_i       (ext_ref_ok_i),
    .ref_osc_sel_i      (ref_osc_sel_i),
    .count_err_i        (count_err_i),
    .count_valid_i      (count_valid_i),
    .osc_output_clock_i (osc_clk),
    .clock_mode_status_o(mode_o),
    .osc_monitor_en_o   (mon_o),
    .reset_req_o        (reset_req_o),
    .irq_o              (irq_o)
  );

  // 50 MHz system clock
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  // oscillator pin at half the clock rate; stopped to look static
  always @(posedge clk_i)
  begin
    if (osc_run)
      osc_clk <= ~osc_clk;
  end

  // idle wait; the #1 lets that edge's updates settle before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic sample(input logic [ERR_W-1:0] v);
    @(posedge clk_i);
    count_err_i   <= v;
    count_valid_i <= 1'b1;
    @(posedge clk_i);
    count_valid_i <= 1'b0;
  endtask : sample

  task automatic loss_pulse();
    @(posedge clk_i);
    clk_loss_i <= 1'b1;
    @(posedge clk_i);
    clk_loss_i <= 1'b0;
    cyc(2);
  endtask : loss_pulse

  // reset values, refused writes, unmapped index
  task automatic t_reset_vals();
    logic [7:0] d;
    wr(OFS_STAT2, 8'hff);
    wr(3'h5, 8'hff);
    for (int i = 0; i < 6; i++)
    begin
      rd(i[2:0], d);
      `CHK("reset value", 8'h00, d)
    end
  endtask : t_reset_vals

  // reference source and external reference stability bits
  task automatic t_status_inputs();
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      ref_osc_sel_i <= i[1];
      ext_ref_ok_i  <= i[0];
      cyc(3);
      rd(OFS_STAT1, d);
      `CHK("ref source", i[1], d[ST1_REF])
      `CHK("ext ref ok", i[0], d[ST1_ERS])
    end
  endtask : t_status_inputs

  // oscillator stable detection, off state, leaving off
  task automatic t_osc();
    logic [7:0] d;
    sample(12'h064);
    sample(12'h12c);
    sample(12'h12e);
    cyc(4);
    rd(OFS_STAT2, d);
    `CHK("osc stable early", 1'b0, d[ST2_OSC])
    `CHK("monitor early", 1'b0, mon_o)
    sample(12'h12f);
    cyc(4);
    rd(OFS_STAT2, d);
    `CHK("osc stable", 1'b1, d[ST2_OSC])
    `CHK("monitor on", 1'b1, mon_o)
    @(posedge clk_i);
    osc_run <= 1'b0;
    cyc(60);
    rd(OFS_STAT2, d);
    `CHK("osc static", 1'b0, d[ST2_OSC])
    @(posedge clk_i);
    osc_run <= 1'b1;
    for (int i = 0; i < 4; i++)
      sample(12'h00a + i[11:0]);
    cyc(4);
    rd(OFS_STAT2, d);
    `CHK("osc restable", 1'b1, d[ST2_OSC])
    @(posedge clk_i);
    gen_off_i <= 1'b1;
    cyc(3);
    rd(OFS_STAT2, d);
    `CHK("osc off", 1'b0, d[ST2_OSC])
    wr(OFS_CTRL, 8'h01);
    cyc(6);
    @(posedge clk_i);
    gen_off_i <= 1'b0;
    cyc(6);
    `CHK("mode waits", 2'b00, mode_o)
    for (int i = 0; i < 4; i++)
      sample(12'h014 + i[11:0]);
    cyc(8);
    `CHK("mode engaged", 2'b01, mode_o)
  endtask : t_osc

  // lock loss raises the flag; clearing sequence
  task automatic t_irq_seq();
    logic [7:0] d;
    @(posedge clk_i);
    lock_i <= 1'b1;
    cyc(3);
    rd(OFS_STAT1, d);
    `CHK("lock bit", 1'b1, d[ST1_LOCK])
    `CHK("mode field", 2'b01, d[7:6])
    @(posedge clk_i);
    lock_i <= 1'b0;
    cyc(3);
    rd(OFS_STAT1, d);
    `CHK("lock loss", 1'b1, d[ST1_LOL])
    `CHK("irq flag", 1'b1, d[ST1_IRQ])
    `CHK("no reset req", 1'b0, reset_req_o)
    `CHK("irq masked", 1'b0, irq_o)
    wr(OFS_MASK, 8'h01);
    cyc(1);
    `CHK("irq line", 1'b1, irq_o)
    // irq set, lock loss, oscillator stable rose, mode changed
    rd(OFS_EVT, d);
    `CHK("event bits", 8'h1b, d)
    wr(OFS_EVT, 8'h1f);
    cyc(1);
    `CHK("irq line clr", 1'b0, irq_o)
    wr(OFS_MASK, 8'h00);
    wr(OFS_STAT1, 8'h00);
    rd(OFS_STAT1, d);
    `CHK("write zero", 1'b1, d[ST1_IRQ])
    wr(OFS_STAT1, 8'h00);
    wr(OFS_STAT1, 8'h01);
    rd(OFS_STAT1, d);
    `CHK("no read first", 1'b1, d[ST1_IRQ])
    loss_pulse();
    wr(OFS_STAT1, 8'h01);
    rd(OFS_STAT1, d);
    `CHK("new irq holds", 1'b1, d[ST1_IRQ])
    `CHK("clock loss", 1'b1, d[ST1_LOC])
    wr(OFS_STAT1, 8'h15);
    rd(OFS_STAT1, d);
    `CHK("flags cleared", 3'b000, {d[4], d[2], d[0]})
  endtask : t_irq_seq

  // reset actions instead of interrupts
  task automatic t_actions();
    logic [7:0] d;
    wr(OFS_CTRL, 8'h89);
    loss_pulse();
    `CHK("loc reset req", 1'b1, reset_req_o)
    rd(OFS_STAT1, d);
    `CHK("loc no irq", 1'b0, d[ST1_IRQ])
    wr(OFS_STAT1, 8'h04);
    cyc(1);
    `CHK("loc req gone", 1'b0, reset_req_o)
    @(posedge clk_i);
    lock_i <= 1'b1;
    cyc(3);
    @(posedge clk_i);
    lock_i <= 1'b0;
    cyc(3);
    `CHK("lol reset req", 1'b1, reset_req_o)
    rd(OFS_STAT1, d);
    `CHK("lol no irq", 1'b0, d[ST1_IRQ])
    wr(OFS_STAT1, 8'h10);
    cyc(1);
    `CHK("lol req gone", 1'b0, reset_req_o)
  endtask : t_actions

  // every mode code, its lag, and the forced lock bit
  task automatic t_modes();
    logic [7:0] d;
    logic [1:0] prev;
    prev = 2'b01;
    @(posedge clk_i);
    lock_i <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_CTRL, {6'h00, m[1:0]});
      cyc(1);
      `CHK("mode lag", prev, mode_o)
      cyc(5);
      `CHK("mode out", m[1:0], mode_o)
      rd(OFS_STAT1, d);
      `CHK("mode read", m[1:0], d[7:6])
      `CHK("lock forced", m[0], d[ST1_LOCK])
      prev = m[1:0];
    end
    `CHK("no lock loss", 1'b0, d[ST1_LOL])
    @(posedge clk_i);
    lock_i <= 1'b0;
  endtask : t_modes

  // a reset in mid-run clears a pending flag
  task automatic t_rst_clear();
    logic [7:0] d;
    wr(OFS_CTRL, 8'h00);
    loss_pulse();
    rd(OFS_STAT1, d);
    `CHK("flag before rst", 1'b1, d[ST1_IRQ])
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_STAT1, d);
    `CHK("flag after rst", 1'b0, d[ST1_IRQ])
  endtask : t_rst_clear

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // watchdog: the whole run needs well under 5000 cycles
  initial
  begin
    #(20 * 5000);
    num_errors++;
    conclude();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_status_inputs();
    t_osc();
    t_irq_seq();
    t_actions();
    t_modes();
    t_rst_clear();
    conclude();
  end
endmodule : cgs_status_tb_top

`default_nettype wire
